// *** testbench.sv ***
// self-checking bench: controller and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock;
    logic        rst;
    logic [1:0]  addr;
    logic [31:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [31:0] rdData;
    logic [7:0]  wZero;
    logic [7:0]  wOne;
    logic [7:0]  wStack;
    logic        stackSel;
    int          errorCnt;
    int          testsRun;
    int          cycles;
    logic [16:0] prevWord;
    logic [7:0]  prevPot0;
    twp_link_if link ();
    twp_host twp_host_inst (.clock(clock), .rst(rst), .link(link), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
    twp_device twp_device_inst (.clock(clock), .rst(rst), .link(link),
        .wiper_terminal_zero(wZero), .wiper_terminal_one(wOne),
        .stacked_wiper_output(wStack), .stackSelect(stackSel));
    twp_link_sva twp_link_sva_inst (.clock(clock), .rst(rst),
        .serialEnable(link.serialEnable), .serialClock(link.serialClock),
        .serialDataIn(link.serialDataIn), .chainOutput(link.chainOutput),
        .wiper_terminal_zero(wZero), .wiper_terminal_one(wOne),
        .stacked_wiper_output(wStack), .stackSelect(stackSel));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1 check(what, rdData, exp);
    endtask
    // stack bit at 0, then each code msb first
    function automatic logic [16:0] mkWord(input logic s, input logic [7:0] p1,
                                          input logic [7:0] p0);
        logic [16:0] w;
        w[0] = s;
        for (int i = 0; i < 8; i++) begin
            w[1+i] = p1[7-i];
            w[9+i] = p0[7-i];
        end
        return w;
    endfunction
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            addr <= 2'h2;
            rdStrobe <= 1'b1;
            @(posedge clock);
            rdStrobe <= 1'b0;
            #1 n++;
        end while (rdData[0] !== 1'b0 && n < 2000);
        if (n >= 2000) check("busy", rdData, 32'h00000000);
        repeat (8) @(posedge clock);
    endtask
    // one frame of n devices; pot0 must stand until enable falls
    task automatic frame(input logic s, input logic [7:0] p1, input logic [7:0] p0,
                         input logic [7:0] n);
        logic [16:0] w;
        w = mkWord(s, p1, p0);
        wr(2'h0, {15'h0000, w});
        wr(2'h1, {24'h000000, n});
        wr(2'h0, 32'h0001ffff);
        repeat (60) @(posedge clock);
        rd(2'h2, 32'h00000001, "busy flag");
        check("pot0 mid frame", {24'h000000, wZero}, {24'h000000, prevPot0});
        waitIdle();
        rd(2'h0, {15'h0000, w}, "data after rotate");
        rd(2'h3, {15'h0000, (n == 8'h01) ? prevWord : w}, "readback");
        check("pot0", {24'h000000, wZero}, {24'h000000, p0});
        check("pot1", {24'h000000, wOne}, {24'h000000, p1});
        check("stack", {31'h00000000, stackSel}, {31'h00000000, s});
        check("stacked", {24'h000000, wStack}, {24'h000000, s ? p1 : p0});
        prevWord = w;
        prevPot0 = p0;
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", errorCnt, testsRun);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // whole run is well under a thousand cycles; ceiling leaves ample margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        addr = 2'h0;
        wrData = 32'h00000000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        errorCnt = 0;
        testsRun = 0;
        cycles = 0;
        prevWord = 17'h00000;
        prevPot0 = 8'h00;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(2'h1, 32'h00000001, "device count");
        check("pot0 reset", {24'h000000, wZero}, 32'h00000000);
        frame(1'b1, 8'ha5, 8'h3c, 8'h01);
        frame(1'b0, 8'h01, 8'h80, 8'h01);
        frame(1'b1, 8'hff, 8'h00, 8'h02);
        wr(2'h1, 32'h00000000);
        rd(2'h2, 32'h00000000, "zero count refused");
        rd(2'h1, 32'h00000002, "count kept");
        check("pot1 idle", {24'h000000, wOne}, 32'h000000ff);
        summarize();
    end
endmodule
`default_nettype wire

// *** twp_device.sv ***
// device end: 17-bit shift chain, commit on enable fall, stacked mux
`timescale 1ns/1ps
`default_nettype none
module twp_device #(
    parameter int REG_BITS  = twp_pkg::REG_BITS,
    parameter int CODE_BITS = twp_pkg::CODE_BITS
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    twp_link_if.device                link,
    output logic      [CODE_BITS-1:0] wiper_terminal_zero,
    output logic      [CODE_BITS-1:0] wiper_terminal_one,
    output logic      [CODE_BITS-1:0] stacked_wiper_output,
    output logic                      stackSelect
);
    ////////////////////////////////////////////////////////////////////
    // each pin crosses into the clock domain through its own two flops
    logic enS;
    logic sclkS;
    logic dinS;

    twp_sync #(.WIDTH(1)) u_syncEnable (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (link.serialEnable),
        .syncOut (enS)
    );
    twp_sync #(.WIDTH(1)) u_syncClock (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (link.serialClock),
        .syncOut (sclkS)
    );
    twp_sync #(.WIDTH(1)) u_syncData (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (link.serialDataIn),
        .syncOut (dinS)
    );

    ////////////////////////////////////////////////////////////////////
    // edges of the synchronised enable and link clock
    logic enPrev_q;
    logic enPrev_d;
    logic sclkPrev_q;
    logic sclkPrev_d;
    logic rise;
    logic fall;

    always_comb begin
        enPrev_d   = enS;
        sclkPrev_d = sclkS;
        // link clock edges count only inside an enable-high frame
        rise       = enS && sclkS && !sclkPrev_q;
        fall       = enPrev_q && !enS;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // idle pin levels, so reset is not followed by a false edge
            enPrev_q   <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            enPrev_q   <= enPrev_d;
            sclkPrev_q <= sclkPrev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one seventeen-stage chain; the newest bit enters the top stage
    logic [REG_BITS-1:0] shifted;
    logic [REG_BITS-1:0] shift_q;
    logic [REG_BITS-1:0] shift_d;

    // each stage takes its upper neighbour, the top stage the pin
    for (genvar k = 0; k < REG_BITS; k++) begin : g_stage
        if (k == REG_BITS - 1) begin : g_top
            assign shifted[k] = dinS;
        end else begin : g_next
            assign shifted[k] = shift_q[k+1];
        end
    end

    always_comb begin
        shift_d = shift_q;
        if (rise) begin
            shift_d = shifted;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_q <= REG_BITS'(twp_pkg::REG_RESET);
        end else begin
            shift_q <= shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit 0 leaves next, and while idle it is the stack bit
    logic chainOut_q;
    logic chainOut_d;

    always_comb begin
        chainOut_d = shift_d[twp_pkg::POS_STACK];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chainOut_q <= 1'b0;
        end else begin
            chainOut_q <= chainOut_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // committed wiper codes and stack bit, loaded only as enable falls
    logic [CODE_BITS-1:0] codeZero;
    logic [CODE_BITS-1:0] codeOne;
    logic [CODE_BITS-1:0] wiperZero_q;
    logic [CODE_BITS-1:0] wiperZero_d;
    logic [CODE_BITS-1:0] wiperOne_q;
    logic [CODE_BITS-1:0] wiperOne_d;
    logic                 stack_q;
    logic                 stack_d;

    // each code sits msb first at its lowest position
    for (genvar j = 0; j < CODE_BITS; j++) begin : g_codeOne
        assign codeOne[CODE_BITS-1-j] = shift_q[twp_pkg::POS_CODE1_MSB+j];
    end
    for (genvar j = 0; j < CODE_BITS; j++) begin : g_codeZero
        assign codeZero[CODE_BITS-1-j] = shift_q[twp_pkg::POS_CODE0_MSB+j];
    end

    always_comb begin
        wiperZero_d = wiperZero_q;
        wiperOne_d  = wiperOne_q;
        stack_d     = stack_q;
        // no bit count is kept: a short frame commits as it stands
        if (fall) begin
            wiperZero_d = codeZero;
            wiperOne_d  = codeOne;
            stack_d     = shift_q[twp_pkg::POS_STACK];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // zero stands in for the undefined power-up state
            wiperZero_q <= '0;
            wiperOne_q  <= '0;
            stack_q     <= 1'b0;
        end else begin
            wiperZero_q <= wiperZero_d;
            wiperOne_q  <= wiperOne_d;
            stack_q     <= stack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stacked output has its own flop so it moves with the wipers
    logic [CODE_BITS-1:0] stacked_q;
    logic [CODE_BITS-1:0] stacked_d;

    always_comb begin
        if (stack_d) begin
            stacked_d = wiperOne_d;
        end else begin
            stacked_d = wiperZero_d;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stacked_q <= '0;
        end else begin
            stacked_q <= stacked_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // every output comes straight from a flop
    assign link.chainOutput     = chainOut_q;
    assign wiper_terminal_zero  = wiperZero_q;
    assign wiper_terminal_one   = wiperOne_q;
    assign stacked_wiper_output = stacked_q;
    assign stackSelect          = stack_q;
endmodule
`default_nettype wire

// *** twp_host.sv ***
// controller end: register-driven writer/reader of the three-wire link
`timescale 1ns/1ps
`default_nettype none
module twp_host #(
    parameter int REG_BITS = twp_pkg::REG_BITS,
    parameter int DIV_HALF = twp_pkg::LINK_DIV_HALF
) (
    input  wire logic        clock,
    input  wire logic        rst,
    twp_link_if.controller   link,
    input  wire logic [1:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [31:0] rdData
);
    ////////////////////////////////////////////////////////////////////
    logic chainS;
    twp_sync #(.WIDTH(1)) u_sync (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (link.chainOutput),
        .syncOut (chainS)
    );

    ////////////////////////////////////////////////////////////////////
    twp_pkg::twp_host_state_t state_q, state_d;
    logic [REG_BITS-1:0] tx_q, tx_d;
    logic [REG_BITS-1:0] rx_q, rx_d;
    logic [7:0]          devs_q, devs_d;
    logic [15:0]         left_q, left_d;
    logic [7:0]          tick_q, tick_d;
    logic                en_q, en_d;
    logic                sclk_q, sclk_d;
    logic                sdo_q, sdo_d;
    logic [31:0]         rd_q, rd_d;
    logic                tickDone;

    always_comb begin
        state_d  = state_q;
        tx_d     = tx_q;
        rx_d     = rx_q;
        devs_d   = devs_q;
        left_d   = left_q;
        en_d     = en_q;
        sclk_d   = sclk_q;
        sdo_d    = sdo_q;
        tickDone = (tick_q == 8'(DIV_HALF - 1));
        tick_d   = tickDone ? 8'h00 : tick_q + 8'h01;
        rd_d     = 32'h00000000;
        if (wrStrobe && addr == twp_pkg::ADDR_DATA && state_q == twp_pkg::TWP_IDLE) begin
            tx_d = wrData[REG_BITS-1:0];
        end
        if (rdStrobe) begin
            unique case (addr)
                twp_pkg::ADDR_DATA:   rd_d = {15'h0000, tx_q};
                twp_pkg::ADDR_CTRL:   rd_d = {24'h000000, devs_q};
                twp_pkg::ADDR_STATUS: rd_d = {31'h00000000, state_q != twp_pkg::TWP_IDLE};
                twp_pkg::ADDR_RDBACK: rd_d = {15'h0000, rx_q};
            endcase
        end
        unique case (state_q)
            twp_pkg::TWP_IDLE: begin
                if (wrStrobe && addr == twp_pkg::ADDR_CTRL && wrData[7:0] != 8'h00) begin
                    devs_d  = wrData[7:0];
                    // seventeen clocks per chained device
                    left_d  = 16'(wrData[7:0] * REG_BITS);
                    en_d    = 1'b1;
                    sdo_d   = tx_q[0];
                    tick_d  = 8'h00;
                    state_d = twp_pkg::TWP_SETUP;
                end
            end
            twp_pkg::TWP_SETUP: if (tickDone) state_d = twp_pkg::TWP_LOW;
            twp_pkg::TWP_LOW: begin
                if (tickDone) begin
                    sclk_d  = 1'b1;
                    state_d = twp_pkg::TWP_HIGH;
                end
            end
            twp_pkg::TWP_HIGH: begin
                if (tickDone) begin
                    sclk_d = 1'b0;
                    // capture bit displaced out of the chain end
                    rx_d   = {chainS, rx_q[REG_BITS-1:1]};
                    tx_d   = {tx_q[0], tx_q[REG_BITS-1:1]};
                    sdo_d  = tx_q[1];
                    left_d = left_q - 16'h0001;
                    state_d = (left_q == 16'h0001) ? twp_pkg::TWP_HOLD
                                                    : twp_pkg::TWP_LOW;
                end
            end
            twp_pkg::TWP_HOLD: begin
                if (tickDone) begin
                    en_d    = 1'b0;
                    state_d = twp_pkg::TWP_IDLE;
                end
            end
            default: state_d = twp_pkg::TWP_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= twp_pkg::TWP_IDLE;
            tx_q    <= twp_pkg::REG_RESET;
            rx_q    <= twp_pkg::REG_RESET;
            devs_q  <= twp_pkg::DEVS_RESET;
            left_q  <= 16'h0000;
            tick_q  <= 8'h00;
            en_q    <= 1'b0;
            sclk_q  <= 1'b0;
            sdo_q   <= 1'b0;
            rd_q    <= 32'h00000000;
        end else begin
            state_q <= state_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            devs_q  <= devs_d;
            left_q  <= left_d;
            tick_q  <= tick_d;
            en_q    <= en_d;
            sclk_q  <= sclk_d;
            sdo_q   <= sdo_d;
            rd_q    <= rd_d;
        end
    end

    assign link.serialEnable = en_q;
    assign link.serialClock  = sclk_q;
    assign link.serialDataIn = sdo_q;
    assign rdData            = rd_q;
endmodule
`default_nettype wire

// *** twp_link_if.sv ***
// three-wire link between controller and potentiometer port
`timescale 1ns/1ps
`default_nettype none
interface twp_link_if;
    logic serialEnable;
    logic serialClock;
    logic serialDataIn;
    logic chainOutput;
    modport controller (output serialEnable, output serialClock, output serialDataIn,
                        input chainOutput);
    modport device (input serialEnable, input serialClock, input serialDataIn,
                    output chainOutput);
endinterface
`default_nettype wire

// *** twp_link_sva.sv ***
// assertions on the three-wire link and on the device's wiper outputs
`timescale 1ns/1ps
`default_nettype none
module twp_link_sva (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       serialEnable,
    input wire logic       serialClock,
    input wire logic       serialDataIn,
    input wire logic       chainOutput,
    input wire logic [7:0] wiper_terminal_zero,
    input wire logic [7:0] wiper_terminal_one,
    input wire logic [7:0] stacked_wiper_output,
    input wire logic       stackSelect
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    sequence highHalf;
        serialClock[*4];
    endsequence
    sequence lowHalf;
        !serialClock[*4];
    endsequence
    // six idle samples cover the sync delay plus the commit flop
    sequence idleLong;
        !serialEnable[*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    sclk_high_width_a: assert property ($rose(serialClock) |-> highHalf)
        else $error("link clock high phase too short");
    sclk_low_width_a: assert property ($fell(serialClock) |-> lowHalf)
        else $error("link clock low phase too short");
    data_at_rise_a: assert property ($rose(serialClock) |-> $stable(serialDataIn))
        else $error("data moved at the sampling edge");
    enable_setup_a: assert property ($rose(serialEnable) |-> lowHalf)
        else $error("link clock not held low after enable rose");
    edge_in_frame_a: assert property ($rose(serialClock) |-> serialEnable)
        else $error("link clock edge outside a frame");
    wiper_hold_a: assert property ((!$stable(wiper_terminal_zero) || !$stable(wiper_terminal_one)
        || !$stable(stackSelect)) |-> !$past(serialEnable) && !$past(serialEnable, 2))
        else $error("wiper moved while a frame was open");
    stack_route_a: assert property (stacked_wiper_output
        == (stackSelect ? wiper_terminal_one : wiper_terminal_zero))
        else $error("stacked output picks the wrong wiper");
    idle_chain_a: assert property (idleLong |-> chainOutput == stackSelect)
        else $error("chain output differs from stack bit while idle");
endmodule
`default_nettype wire

// *** twp_pkg.sv ***
// shared constants for the three-wire wiper port
package twp_pkg;
    localparam int REG_BITS       = 17;
    localparam int CODE_BITS      = 8;
    localparam int POS_STACK      = 0;
    localparam int POS_CODE1_MSB  = 1;
    localparam int POS_CODE0_MSB  = 9;
    localparam int SYNC_STAGES    = 2;
    localparam int LINK_DIV_HALF  = 4;
    localparam int HOST_SETUP_CYC = 2;
    localparam logic [16:0] REG_RESET = 17'h00000;
    localparam logic [1:0]  ADDR_DATA   = 2'h0;
    localparam logic [1:0]  ADDR_CTRL   = 2'h1;
    localparam logic [1:0]  ADDR_STATUS = 2'h2;
    localparam logic [1:0]  ADDR_RDBACK = 2'h3;
    localparam logic [7:0]  DEVS_RESET  = 8'h01;
    typedef enum logic [2:0] {
        TWP_IDLE  = 3'b000,
        TWP_SETUP = 3'b001,
        TWP_LOW   = 3'b010,
        TWP_HIGH  = 3'b011,
        TWP_HOLD  = 3'b100
    } twp_host_state_t;
endpackage

// *** twp_sync.sv ***
// two-flop synchroniser for a bundle of link levels
`timescale 1ns/1ps
`default_nettype none
module twp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire
